/* arrb_host_model.sv */
// Purpose: Host side that drains the return result queue
// Assumes: Packet outputs settle one cycle after each pop
// Notes:   Caller picks the idle gap between pops for a slow host
`timescale 1ns/10ps
module arrb_host_model (
   input  wire logic        clk,
   input  wire logic        pktValid,
   input  wire logic [7:0]  pktAxis,
   input  wire logic [7:0]  pktFunctionCode,
   input  wire logic [15:0] pktWordHi,
   input  wire logic [15:0] pktWordLo,
   output logic             hostMode2,
   output logic             hostRead
);
   logic [47:0] got[$];  // Packets taken, oldest first
   initial begin
      hostMode2 = 1'b0;
      hostRead  = 1'b0;
   end
   // Pops up to n packets; stops early when the queue runs dry
   task popN(input int n, input int gap);
      for (int k = 0; k < n; k++) begin
         if (pktValid !== 1'b1) break;
         hostMode2 = 1'b1;
         hostRead  = 1'b1;
         got.push_back({pktAxis, pktFunctionCode, pktWordHi, pktWordLo});
         @(posedge clk);
         #1;
         if (gap > 0) begin
            hostRead  = 1'b0;
            hostMode2 = 1'b0;
            repeat (gap) @(posedge clk);
            #1;
         end
      end
      hostRead  = 1'b0;
      hostMode2 = 1'b0;
   endtask
endmodule

/* arrb_pkg.sv */
// Purpose: Shared constants for the axis readback return buffer
// Assumes: One controller clock, synchronous inputs
// Notes:   Function codes and value limits used by the readback logic
package arrb_pkg;
   // Function codes tagged onto queue packets
   localparam logic [7:0] FC_READ_POS = 8'h01; // Position readback
   localparam logic [7:0] FC_READ_VEL = 8'h02; // Velocity readback
   // Servo position limits
   localparam logic signed [31:0] SERVO_POS_MIN = 32'shC0000000;
   localparam logic signed [31:0] SERVO_POS_MAX = 32'sh3FFFFFFF;
   // Servo velocity limits, counts per sample period
   localparam logic signed [15:0] SERVO_VEL_MIN = 16'shC000;
   localparam logic signed [15:0] SERVO_VEL_MAX = 16'sh3FFF;
   // Stepper step rate limits, steps per second
   localparam logic [31:0] STEP_VEL_MIN = 32'h00000001;
   localparam logic [31:0] STEP_VEL_MAX = 32'h00100000;
   // Stepper operation modes
   typedef enum logic [1:0] {
      ARRB_OPM_REL = 2'b00,
      ARRB_OPM_ABS = 2'b01,
      ARRB_OPM_VEL = 2'b10
   } arrb_opmode_e;
   // Reset value of the queue pointers
   localparam logic [7:0] PTR_RESET = 8'h00;
endpackage

/* arrb_readback.sv */
// Purpose: Samples axis position and velocity into a return result queue
// Assumes: Requests and host reads are synchronous to clk
// Notes:   Queue is an in-order array; host pops one packet per clock while hostRead and hostMode2 are high
`timescale 1ns/10ps
module arrb_readback
   import arrb_pkg::*;
#(
   parameter int NUM_AXES  = 4,   // Axis count
   parameter int DEPTH     = 16,  // Queue depth in packets
   parameter bit IS_STEPPER = 1'b0 // 1 selects stepper variant
)(
   input  wire logic                        clk,
   input  wire logic                        arst_n,
   input  wire logic                        reqValid,
   input  wire logic                        reqIsVel,
   input  wire logic [7:0]                  reqAxis,
   input  wire logic [NUM_AXES*32-1:0]      axisPos,
   input  wire logic [NUM_AXES*32-1:0]      axisVel,
   input  wire logic [NUM_AXES*32-1:0]      axisMaxVel,
   input  wire logic [NUM_AXES*2-1:0]       axisMode,
   input  wire logic                        hostMode2,
   input  wire logic                        hostRead,
   output logic                             reqReady,
   output logic                             pktValid,
   output logic [7:0]                       pktAxis,
   output logic [7:0]                       pktFunctionCode,
   output logic [15:0]                      pktWordHi,
   output logic [15:0]                      pktWordLo,
   output logic [7:0]                       pktCount,
   output logic [NUM_AXES-1:0]              stepDirReverse,
   output logic [NUM_AXES*32-1:0]           stepRate
);
   // Pointers wrap at a power of two, so only such depths index the array safely
   if (DEPTH < 2 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0 ||
       NUM_AXES < 1 || NUM_AXES > 255) begin : g_badParams
      $error("arrb_readback: unsupported parameters");
   end

   localparam int AW = $clog2(DEPTH);

   // Reset synchroniser
   logic rstMeta;
   logic rstSync;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end
   wire logic rst_n = rstSync;

   // Queue storage; packet = axis, code, data word pair
   logic [7:0]  qAxis [DEPTH];                 // Axis identifiers
   logic [7:0]  qCode [DEPTH];                 // Function codes
   logic [31:0] qData [DEPTH];                 // Two 16-bit words
   logic [AW-1:0] wrPtr;                       // Next free slot
   logic [AW-1:0] rdPtr;                       // Oldest packet
   logic [7:0]    count;                       // Packets held

   // Selected axis inputs, index bounded to legal axes
   logic        axisOk;
   logic [31:0] selPos;
   logic [31:0] selVel;
   logic [1:0]  selMode;
   logic [31:0] next_data;
   logic        doPush;
   logic        doPop;

   always_comb begin
      axisOk  = (reqAxis < 8'(NUM_AXES));
      selPos  = 32'h0;
      selVel  = 32'h0;
      selMode = 2'b00;
      if (axisOk) begin
         selPos  = axisPos[reqAxis*32 +: 32];   // instantaneous scaled count
         selVel  = axisVel[reqAxis*32 +: 32];
         selMode = axisMode[reqAxis*2 +: 2];
      end
   end

   // Format the captured value per variant
   always_comb begin
      next_data = 32'h0;
      if (!reqIsVel) begin
         if (IS_STEPPER) begin
            // Velocity mode has no meaningful position
            if (selMode == ARRB_OPM_VEL)
               next_data = 32'h0;
            else
               next_data = selPos;
         end else if ($signed(selPos) > SERVO_POS_MAX) begin
            next_data = SERVO_POS_MAX;
         end else if ($signed(selPos) < SERVO_POS_MIN) begin
            next_data = SERVO_POS_MIN;
         end else begin
            next_data = selPos;
         end
      end else if (IS_STEPPER) begin
         // Magnitude only; direction leaves on stepDirReverse
         next_data = selVel[31] ? 32'(-selVel) : selVel;
         if (next_data > STEP_VEL_MAX) next_data = STEP_VEL_MAX;
         else if (next_data < STEP_VEL_MIN) next_data = STEP_VEL_MIN;
      end else begin
         // Integer half of signed velocity, sign kept for direction
         if ($signed(selVel[31:16]) > SERVO_VEL_MAX)
            next_data = {{16{1'b0}}, SERVO_VEL_MAX};
         else if ($signed(selVel[31:16]) < SERVO_VEL_MIN)
            next_data = {{16{1'b1}}, SERVO_VEL_MIN};
         else
            next_data = {{16{selVel[31]}}, selVel[31:16]};
      end
   end

   // Requests stall while full so no result is dropped
   assign reqReady = (count < 8'(DEPTH));
   assign doPush   = reqValid && reqReady && axisOk;
   assign doPop    = hostRead && hostMode2 && (count != 8'h0);

   // Queue write
   always_ff @(posedge clk) begin
      if (doPush) begin
         qAxis[wrPtr] <= reqAxis;
         qCode[wrPtr] <= reqIsVel ? FC_READ_VEL : FC_READ_POS;
         qData[wrPtr] <= next_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= AW'(PTR_RESET);
         rdPtr <= AW'(PTR_RESET);
         count <= PTR_RESET;
      end else begin
         if (doPush) wrPtr <= AW'(wrPtr + 1'b1);
         if (doPop) rdPtr <= AW'(rdPtr + 1'b1);
         count <= 8'(count + (doPush ? 8'h1 : 8'h0) - (doPop ? 8'h1 : 8'h0));
      end
   end

   // Head packet registered out, oldest first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pktValid        <= 1'b0;
         pktAxis         <= 8'h00;
         pktFunctionCode <= 8'h00;
         pktWordHi       <= 16'h0000;
         pktWordLo       <= 16'h0000;
         pktCount        <= 8'h00;
      end else begin
         // Only packets present are offered
         pktValid        <= (count != 8'h0) && !(doPop && count == 8'h1);
         pktAxis         <= qAxis[doPop ? AW'(rdPtr + 1'b1) : rdPtr];
         pktFunctionCode <= qCode[doPop ? AW'(rdPtr + 1'b1) : rdPtr];
         {pktWordHi, pktWordLo} <= qData[doPop ? AW'(rdPtr + 1'b1) : rdPtr];
         pktCount        <= 8'(count + (doPush ? 8'h1 : 8'h0) - (doPop ? 8'h1 : 8'h0));
      end
   end

   // Step generator rate limit and direction per axis
   for (genvar a = 0; a < NUM_AXES; a++) begin : g_step
      wire logic [31:0] mag = axisVel[a*32+31] ? 32'(-axisVel[a*32 +: 32])
                                               : axisVel[a*32 +: 32];
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            stepRate[a*32 +: 32] <= 32'h0;
            stepDirReverse[a]    <= 1'b0;
         end else begin
            // Never step faster than programmed maximum
            stepRate[a*32 +: 32] <= (mag > axisMaxVel[a*32 +: 32])
                                    ? axisMaxVel[a*32 +: 32] : mag;
            stepDirReverse[a]    <= axisVel[a*32+31];
         end
      end
   end

   // Checks
   property p_noOverflow;
      @(posedge clk) disable iff (!rst_n) count <= 8'(DEPTH);
   endproperty
   a_noOverflow: assert property (p_noOverflow) else $error("queue overflow");

   property p_popCount;
      @(posedge clk) disable iff (!rst_n) (doPop && !doPush) |=> count == $past(count) - 8'h1;
   endproperty
   a_popCount: assert property (p_popCount) else $error("pop count wrong");

   property p_emptyNoValid;
      @(posedge clk) disable iff (!rst_n) (count == 8'h0) |-> !pktValid;
   endproperty
   a_emptyNoValid: assert property (p_emptyNoValid) else $error("valid while empty");

   property p_stepLimit;
      @(posedge clk) disable iff (!rst_n) stepRate[31:0] <= $past(axisMaxVel[31:0]) || !$past(rst_n);
   endproperty
   a_stepLimit: assert property (p_stepLimit) else $error("step rate over max");

   property p_stepVelZero;
      @(posedge clk) disable iff (!rst_n)
         (IS_STEPPER && doPush && !reqIsVel && selMode == ARRB_OPM_VEL) |-> next_data == 32'h0;
   endproperty
   a_stepVelZero: assert property (p_stepVelZero) else $error("velocity mode pos nonzero");

   property p_servoPosRange;
      @(posedge clk) disable iff (!rst_n) (!IS_STEPPER && doPush && !reqIsVel)
         |-> ($signed(next_data) <= SERVO_POS_MAX && $signed(next_data) >= SERVO_POS_MIN);
   endproperty
   a_servoPosRange: assert property (p_servoPosRange) else $error("servo pos range");

   property p_stepVelRange;
      @(posedge clk) disable iff (!rst_n) (IS_STEPPER && doPush && reqIsVel)
         |-> (next_data >= STEP_VEL_MIN && next_data <= STEP_VEL_MAX);
   endproperty
   a_stepVelRange: assert property (p_stepVelRange) else $error("step vel range");

   property p_servoVelSign;
      @(posedge clk) disable iff (!rst_n) (!IS_STEPPER && doPush && reqIsVel)
         |-> next_data[31] == selVel[31];
   endproperty
   a_servoVelSign: assert property (p_servoVelSign) else $error("servo vel sign");
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the servo and stepper readback queues
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Depth shrunk to 4 so the full case is cheap
`timescale 1ns/10ps
module tb
   import arrb_pkg::*;
;
   logic        clk = 1'b0, arst_n = 1'b0, reqValid = 1'b0, reqIsVel = 1'b0;
   logic [7:0]  reqAxis = 8'h00, pktAxis, pktFunctionCode, pktCount;
   logic [63:0] axisPos = '0, axisVel = '0, axisMaxVel = 64'h0000100000000400;
   logic [3:0]  axisMode = 4'h9;
   logic        hostMode2, hostRead, reqReady, pktValid;
   logic [15:0] pktWordHi, pktWordLo;
   int          miscompares = 0, totalChecks = 0;
   logic        useStep = 1'b0;  // Steers requests to the stepper copy
   logic [63:0] stepRate;        // Limited step rate, servo copy
   logic [1:0]  stepDirReverse;  // Direction flags, servo copy
   always #50 clk = ~clk;  // 10 MHz
   arrb_readback #(.NUM_AXES(2), .DEPTH(4), .IS_STEPPER(1'b0)) i_arrb_readback (
      .clk, .arst_n, .reqValid(reqValid && !useStep), .reqIsVel, .reqAxis,
      .axisPos, .axisVel,
      .axisMaxVel, .axisMode, .hostMode2, .hostRead, .reqReady, .pktValid,
      .pktAxis, .pktFunctionCode, .pktWordHi, .pktWordLo, .pktCount,
      .stepDirReverse, .stepRate);
   arrb_host_model i_arrb_host_model (
      .clk, .pktValid, .pktAxis, .pktFunctionCode, .pktWordHi, .pktWordLo,
      .hostMode2, .hostRead);
   // Stepper copy with its own host, fed only while useStep is high
   if (1) begin : g_stepper
      logic        hostMode2, hostRead, reqReady, pktValid;
      logic [7:0]  pktAxis, pktFunctionCode, pktCount;
      logic [15:0] pktWordHi, pktWordLo;
      arrb_readback #(.NUM_AXES(2), .DEPTH(4), .IS_STEPPER(1'b1)) i_arrb_readback (
         .clk, .arst_n, .reqValid(reqValid && useStep), .reqIsVel, .reqAxis,
         .axisPos, .axisVel,
         .axisMaxVel, .axisMode, .hostMode2, .hostRead, .reqReady, .pktValid,
         .pktAxis, .pktFunctionCode, .pktWordHi, .pktWordLo, .pktCount,
         .stepDirReverse(), .stepRate());
      arrb_host_model i_arrb_host_model (
         .clk, .pktValid, .pktAxis, .pktFunctionCode, .pktWordHi, .pktWordLo,
         .hostMode2, .hostRead);
   end
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Request held one edge; valid stays up for back to back use
   task req(input logic [7:0] a, input logic v);
      reqValid = 1'b1;
      reqAxis  = a;
      reqIsVel = v;
      @(posedge clk);
      #1;
   endtask
   task endReq;
      reqValid = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // Packet k: axis, code and low word only
   task vchk(input int k, input logic [7:0] a, input logic [15:0] v);
      chk({i_arrb_host_model.got[k][47:32], i_arrb_host_model.got[k][15:0]},
          {16'h0000, a, FC_READ_VEL, v});
   endtask
   // Position moves between captures; range ends saturate
   task scenPos;
      axisPos = {32'h7FFFFFFF, 32'h12345678};
      req(8'h00, 1'b0);
      axisPos[31:0] = 32'h00000009;
      req(8'h01, 1'b0);
      axisPos[63:32] = 32'h80000000;
      req(8'h01, 1'b0);
      req(8'h00, 1'b0);
      endReq;
      repeat (6) @(posedge clk);
      #1;
      chk({40'h0, pktCount}, 48'h4);
      i_arrb_host_model.popN(6, 0);
      chk(48'(i_arrb_host_model.got.size()), 48'h4);
      chk(i_arrb_host_model.got[0], {8'h00, FC_READ_POS, 32'h12345678});
      chk(i_arrb_host_model.got[1], {8'h01, FC_READ_POS, SERVO_POS_MAX});
      chk(i_arrb_host_model.got[2], {8'h01, FC_READ_POS, SERVO_POS_MIN});
      chk(i_arrb_host_model.got[3], {8'h00, FC_READ_POS, 32'h00000009});
      chk({47'h0, pktValid}, 48'h0);
      i_arrb_host_model.got.delete();
   endtask
   // Fraction dropped, sign kept, integer part clamped
   task scenVel;
      axisVel = {32'h70000000, 32'hFFFD8000};
      req(8'h00, 1'b1);
      chk({46'h0, stepDirReverse}, 48'h1);
      chk({16'h0, stepRate[31:0]}, 48'h400);
      chk({16'h0, stepRate[63:32]}, 48'h1000);
      axisVel[31:0] = 32'h0005FFFF;
      req(8'h00, 1'b1);
      req(8'h01, 1'b1);
      endReq;
      chk({46'h0, stepDirReverse}, 48'h0);
      i_arrb_host_model.popN(3, 2);
      vchk(0, 8'h00, 16'hFFFD);
      vchk(1, 8'h00, 16'h0005);
      vchk(2, 8'h01, SERVO_VEL_MAX);
      i_arrb_host_model.got.delete();
   endtask
   // Bad axis ignored, fill to refusal, drain slowly in order
   task scenFull;
      logic [15:0] tags[4];
      tags = '{{8'h00, FC_READ_POS}, {8'h01, FC_READ_VEL},
               {8'h00, FC_READ_VEL}, {8'h01, FC_READ_POS}};
      req(8'h05, 1'b0);
      req(8'h00, 1'b0);
      req(8'h01, 1'b1);
      req(8'h00, 1'b1);
      req(8'h01, 1'b0);
      chk({47'h0, reqReady}, 48'h0);
      req(8'h00, 1'b0);
      endReq;
      chk({40'h0, pktCount}, 48'h4);
      i_arrb_host_model.popN(8, 1);
      chk(48'(i_arrb_host_model.got.size()), 48'h4);
      for (int k = 0; k < 4; k++) begin
         chk({32'h0, i_arrb_host_model.got[k][47:32]}, {32'h0, tags[k]});
      end
      chk({39'h0, pktValid, pktCount}, 48'h0);
   endtask
   // Stepper: full-range position, zero in velocity mode, clamped magnitude
   task scenStep;
      useStep = 1'b1;
      axisPos = {32'h80000000, 32'h80000001};
      axisVel = {32'h00000000, 32'hFFF00000};
      req(8'h00, 1'b0);
      req(8'h01, 1'b0);
      req(8'h00, 1'b1);
      req(8'h01, 1'b1);
      endReq;
      useStep = 1'b0;
      chk({40'h0, g_stepper.pktCount}, 48'h4);
      chk({46'h0, stepDirReverse}, 48'h1);
      chk({16'h0, stepRate[31:0]}, 48'h400);
      chk({16'h0, stepRate[63:32]}, 48'h0);
      g_stepper.i_arrb_host_model.popN(4, 0);
      chk(48'(g_stepper.i_arrb_host_model.got.size()), 48'h4);
      chk(g_stepper.i_arrb_host_model.got[0], {8'h00, FC_READ_POS, 32'h80000001});
      chk(g_stepper.i_arrb_host_model.got[1], {8'h01, FC_READ_POS, 32'h00000000});
      chk(g_stepper.i_arrb_host_model.got[2], {8'h00, FC_READ_VEL, STEP_VEL_MAX});
      chk(g_stepper.i_arrb_host_model.got[3], {8'h01, FC_READ_VEL, STEP_VEL_MIN});
      chk({47'h0, g_stepper.pktValid}, 48'h0);
   endtask
   task print_verdict;
      if (miscompares == 0 && totalChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
   initial begin
      repeat (5) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({38'h0, reqReady, pktValid, pktCount}, {38'h0, 1'b1, 1'b0, 8'h00});
      scenPos;
      scenVel;
      scenFull;
      scenStep;
      print_verdict;
   end
endmodule
